// ==== sq_map.svh ====
// Offsets, field positions, reset values and sizes of the controlled sequencer
// How it works
// - Banks change by configured advance/restart sources, step/rewind commands and enabling
// - Banks used ascending, wrap to zero after top
// - Bank count never exceeds sixty-four
// - Sync advance/restart evaluated only at frame start
// - Unsynced step command advances one bank anytime while enabled
// - Unsynced rewind command returns to bank zero
// - Disabled advance source: no sync step, commands work
// - Always-active source steps on every frame trigger
// - Line status one steps, zero holds bank
// - Line status is level, flipped when inverted
// - Restart line status one rewinds at frame start
// - Disabled restart source: no sync rewind, commands work
// - Bank selector spans zero to sixty-three
// - Unstored banks within total read default values
// - Store copies active set into selected bank
// - Load copies selected bank into active set
// - Banks kept in volatile storage only
// - Enabling loads bank zero into active set
// - Sync restart beats sync advance on same frame
// - Sync restart loads bank zero before acquisition
// - Each step command counts as one step, up to 127 pending
`ifndef SQ_MAP_SVH
`define SQ_MAP_SVH

`define SQ_OFF_CTRL     8'h00
`define SQ_OFF_TOTAL    8'h04
`define SQ_OFF_SRC      8'h08
`define SQ_OFF_INV      8'h0C
`define SQ_OFF_INDEX    8'h10
`define SQ_OFF_CMD      8'h14
`define SQ_OFF_ACTIVE   8'h18
`define SQ_OFF_STATUS   8'h1C

`define SQ_CTRL_EN_BIT  0
`define SQ_SRC_ADV_LSB  0
`define SQ_SRC_RST_LSB  2
`define SQ_CMD_STORE    0
`define SQ_CMD_LOAD     1
`define SQ_CMD_STEP     2
`define SQ_CMD_REWIND   3

`define SQ_BANK_MAX     7'h40
`define SQ_TOTAL_RST    7'h01
`define SQ_DEFAULT_SET  32'h0000_0000
`define SQ_STEPS_MAX    7'h7F

`endif

// ==== sq_pkg.sv ====
// Types shared by the controlled sequencer modules
package sq_pkg;
    typedef logic [5:0]  sq_bank_t;
    typedef logic [31:0] sq_word_t;

    typedef enum logic [1:0] {
        SQ_SRC_OFF    = 2'b00,
        SQ_SRC_ALWAYS = 2'b01,
        SQ_SRC_LINE1  = 2'b10,
        SQ_SRC_LINE2  = 2'b11
    } sq_src_e;

    typedef enum logic {
        SQ_IDLE  = 1'b0,
        SQ_FETCH = 1'b1
    } sq_state_e;
endpackage

// ==== sq_mem_if.sv ====
// Port between the sequencer control and its bank memory
`timescale 1ns/1ps
interface sq_mem_if;
    logic             we;
    logic             re;
    sq_pkg::sq_bank_t addr;
    sq_pkg::sq_word_t wdata;
    sq_pkg::sq_word_t rdata;

    modport ctl (output we, output re, output addr, output wdata, input rdata);
    modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

// ==== sq_bank_mem.sv ====
// Volatile store of the sixty-four parameter banks, registered read
`timescale 1ns/1ps
module sq_bank_mem (
    input  wire logic i_clk_sys,
    sq_mem_if.mem     mp
);
    // No reset on the array: contents are lost with power anyway
    sq_pkg::sq_word_t mem [0:63];

    always_ff @(posedge i_clk_sys) begin
        if (mp.we) begin
            mem[mp.addr] <= mp.wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (mp.re) begin
            mp.rdata <= mem[mp.addr];
        end
    end
endmodule // sq_bank_mem

// ==== sq_controlled_seq.sv ====
// Controlled-advance parameter bank sequencer with register port
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "sq_map.svh"
module sq_controlled_seq (
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_frame_start,
    input  wire logic        i_line1,
    input  wire logic        i_line2,
    output logic      [31:0] o_active_set,
    output logic      [5:0]  o_bank,
    output logic             o_set_loaded
);
    sq_mem_if mio();

    sq_bank_mem u_mem (
        .i_clk_sys (i_clk_sys),
        .mp        (mio.mem)
    );

    logic               enable;
    logic [6:0]         total;
    sq_pkg::sq_src_e    adv_src;
    sq_pkg::sq_src_e    rst_src;
    logic [1:0]         inv;
    sq_pkg::sq_bank_t   index;
    sq_pkg::sq_word_t   active;
    sq_pkg::sq_bank_t   bank;
    logic [63:0]        valid;
    logic [1:0]         line_meta;
    logic [1:0]         line_sync;
    sq_pkg::sq_state_e  state;
    sq_pkg::sq_bank_t   tgt_q;
    logic               seq_q;
    logic               tgt_valid;
    logic               pend_start;
    logic               pend_sync_rst;
    logic               pend_sync_adv;
    logic               pend_rewind;
    logic               pend_load;
    logic               pend_store;
    logic [6:0]         pend_steps;
    logic               go;
    logic               go_seq;
    logic               do_store;
    sq_pkg::sq_bank_t   go_tgt;
    logic [6:0]         clr;
    logic               wr_cmd;
    logic               adv_hit;
    logic               rst_hit;
    logic               frame_on;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
        sel = (a == off);
    endfunction

    // Logical status of the chosen source; restart has no always-on choice
    function automatic logic src_hit(input sq_pkg::sq_src_e s, input logic [1:0] ln,
                                     input logic [1:0] iv, input logic allow_always);
        case (s)
            sq_pkg::SQ_SRC_ALWAYS: src_hit = allow_always;
            sq_pkg::SQ_SRC_LINE1:  src_hit = ln[0] ^ iv[0];
            sq_pkg::SQ_SRC_LINE2:  src_hit = ln[1] ^ iv[1];
            default:               src_hit = 1'b0;
        endcase
    endfunction

    function automatic sq_pkg::sq_bank_t next_bank(input sq_pkg::sq_bank_t b,
                                                   input logic [6:0] t);
        if ({1'b0, b} >= t - 7'h01) begin
            next_bank = 6'h00;
        end else begin
            next_bank = b + 6'h01;
        end
    endfunction

    // Lines are asynchronous pins; the first stage feeds only the second
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            line_meta <= 2'h0;
            line_sync <= 2'h0;
        end else begin
            line_meta <= {i_line2, i_line1};
            line_sync <= line_meta;
        end
    end

    assign wr_cmd   = i_wr && sel(i_addr, `SQ_OFF_CMD);
    assign frame_on = enable && i_frame_start;
    assign adv_hit  = src_hit(adv_src, line_sync, inv, 1'b1);
    assign rst_hit  = src_hit(rst_src, line_sync, inv, 1'b0);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            enable  <= 1'b0;
            total   <= `SQ_TOTAL_RST;
            adv_src <= sq_pkg::SQ_SRC_OFF;
            rst_src <= sq_pkg::SQ_SRC_OFF;
            inv     <= 2'h0;
            index   <= 6'h00;
        end else if (i_wr) begin
            if (sel(i_addr, `SQ_OFF_CTRL)) begin
                enable <= i_wdata[`SQ_CTRL_EN_BIT];
            end
            if (sel(i_addr, `SQ_OFF_TOTAL)) begin
                if (i_wdata[6:0] == 7'h00) begin
                    total <= 7'h01;
                end else if (i_wdata[31:7] != 25'h0 || i_wdata[6:0] > `SQ_BANK_MAX) begin
                    total <= `SQ_BANK_MAX;
                end else begin
                    total <= i_wdata[6:0];
                end
            end
            if (sel(i_addr, `SQ_OFF_SRC)) begin
                adv_src <= sq_pkg::sq_src_e'(i_wdata[`SQ_SRC_ADV_LSB +: 2]);
                rst_src <= sq_pkg::sq_src_e'(i_wdata[`SQ_SRC_RST_LSB +: 2]);
            end
            if (sel(i_addr, `SQ_OFF_INV)) begin
                inv <= i_wdata[1:0];
            end
            if (sel(i_addr, `SQ_OFF_INDEX)) begin
                index <= i_wdata[5:0];
            end
        end
    end

    // Pending work; a new request in the cycle it is taken keeps it set
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pend_start    <= 1'b0;
            pend_sync_rst <= 1'b0;
            pend_sync_adv <= 1'b0;
            pend_rewind   <= 1'b0;
            pend_steps    <= 7'h00;
        end else if (!enable) begin
            pend_start    <= i_wr && sel(i_addr, `SQ_OFF_CTRL) && i_wdata[`SQ_CTRL_EN_BIT];
            pend_sync_rst <= 1'b0;
            pend_sync_adv <= 1'b0;
            pend_rewind   <= 1'b0;
            pend_steps    <= 7'h00;
        end else begin
            if (i_wr && sel(i_addr, `SQ_OFF_CTRL) && !i_wdata[`SQ_CTRL_EN_BIT]) begin
                pend_start <= 1'b0;
            end else if (clr[0]) begin
                pend_start <= 1'b0;
            end
            if (frame_on) begin
                pend_sync_rst <= rst_hit;
                pend_sync_adv <= adv_hit && !rst_hit;
            end else begin
                if (clr[1]) begin
                    pend_sync_rst <= 1'b0;
                end
                if (clr[2]) begin
                    pend_sync_adv <= 1'b0;
                end
            end
            if (wr_cmd && i_wdata[`SQ_CMD_REWIND]) begin
                pend_rewind <= 1'b1;
            end else if (clr[3]) begin
                pend_rewind <= 1'b0;
            end
            // Saturates at SQ_STEPS_MAX rather than wrapping; steps beyond 127 pending are dropped
            if (wr_cmd && i_wdata[`SQ_CMD_STEP] && !clr[4] && pend_steps != `SQ_STEPS_MAX) begin
                pend_steps <= pend_steps + 7'h01;
            end else if (!(wr_cmd && i_wdata[`SQ_CMD_STEP]) && clr[4]) begin
                pend_steps <= pend_steps - 7'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pend_load  <= 1'b0;
            pend_store <= 1'b0;
        end else begin
            if (wr_cmd && i_wdata[`SQ_CMD_LOAD]) begin
                pend_load <= 1'b1;
            end else if (clr[5]) begin
                pend_load <= 1'b0;
            end
            if (wr_cmd && i_wdata[`SQ_CMD_STORE]) begin
                pend_store <= 1'b1;
            end else if (clr[6]) begin
                pend_store <= 1'b0;
            end
        end
    end

    // One piece of work per idle cycle, in fixed priority
    always_comb begin
        go       = 1'b0;
        go_seq   = 1'b0;
        do_store = 1'b0;
        go_tgt   = bank;
        clr      = 7'h00;
        if (state == sq_pkg::SQ_IDLE) begin
            if (pend_start) begin
                go = 1'b1; go_seq = 1'b1; go_tgt = 6'h00; clr[0] = 1'b1;
            end else if (pend_sync_rst) begin
                go = 1'b1; go_seq = 1'b1; go_tgt = 6'h00; clr[1] = 1'b1;
            end else if (pend_sync_adv) begin
                go = 1'b1; go_seq = 1'b1; go_tgt = next_bank(bank, total);
                clr[2] = 1'b1;
            end else if (pend_rewind) begin
                go = 1'b1; go_seq = 1'b1; go_tgt = 6'h00; clr[3] = 1'b1;
            end else if (pend_steps != 7'h00) begin
                go = 1'b1; go_seq = 1'b1; go_tgt = next_bank(bank, total);
                clr[4] = 1'b1;
            end else if (pend_load) begin
                go = 1'b1; go_tgt = index; clr[5] = 1'b1;
            end else if (pend_store) begin
                do_store = 1'b1; clr[6] = 1'b1;
            end
        end
    end

    always_comb begin
        mio.re    = go;
        mio.we    = do_store;
        mio.addr  = do_store ? index : go_tgt;
        mio.wdata = active;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state     <= sq_pkg::SQ_IDLE;
            tgt_q     <= 6'h00;
            seq_q     <= 1'b0;
            tgt_valid <= 1'b0;
        end else begin
            case (state)
                sq_pkg::SQ_IDLE: begin
                    if (go) begin
                        state     <= sq_pkg::SQ_FETCH;
                        tgt_q     <= go_tgt;
                        seq_q     <= go_seq;
                        tgt_valid <= valid[go_tgt];
                    end
                end
                default: begin
                    state <= sq_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    // Valid map is what makes never-stored banks read back as defaults
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            valid <= 64'h0;
        end else if (do_store) begin
            valid[index] <= 1'b1;
        end
    end

    // Sequencer loads win over a host write to the active set in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            active       <= `SQ_DEFAULT_SET;
            bank         <= 6'h00;
            o_set_loaded <= 1'b0;
        end else begin
            o_set_loaded <= (state == sq_pkg::SQ_FETCH);
            if (state == sq_pkg::SQ_FETCH) begin
                active <= tgt_valid ? mio.rdata : `SQ_DEFAULT_SET;
                if (seq_q) begin
                    bank <= tgt_q;
                end
            end else if (i_wr && sel(i_addr, `SQ_OFF_ACTIVE)) begin
                active <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                `SQ_OFF_CTRL:   o_rdata <= {31'h0, enable};
                `SQ_OFF_TOTAL:  o_rdata <= {25'h0, total};
                `SQ_OFF_SRC:    o_rdata <= {28'h0, rst_src, adv_src};
                `SQ_OFF_INV:    o_rdata <= {30'h0, inv};
                `SQ_OFF_INDEX:  o_rdata <= {26'h0, index};
                `SQ_OFF_ACTIVE: o_rdata <= active;
                `SQ_OFF_STATUS: o_rdata <= {16'h0, enable, pend_steps,
                                            state == sq_pkg::SQ_FETCH, 1'b0, bank};
                default:        o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    assign o_active_set = active;
    assign o_bank       = bank;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    sequence s_bank0_loaded;
        o_set_loaded && (o_bank == 6'h00);
    endsequence

    property p_total_max;
        (total <= `SQ_BANK_MAX) && (total != 7'h00);
    endproperty
    a_total_max: assert property (p_total_max) else $error("bank total out of range");

    property p_wrap;
        (go && go_seq && (clr[2] || clr[4]) && ({1'b0, bank} == total - 7'h01))
            |=> (tgt_q == 6'h00) ##1 (o_bank == 6'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("top bank did not wrap to zero");

    property p_restart_wins;
        (frame_on && rst_hit) |=> (pend_sync_rst && !pend_sync_adv);
    endproperty
    a_restart_wins: assert property (p_restart_wins) else $error("advance kept over restart");

    property p_adv_off;
        (frame_on && adv_src == sq_pkg::SQ_SRC_OFF) |=> !pend_sync_adv;
    endproperty
    a_adv_off: assert property (p_adv_off) else $error("sync step with source off");

    property p_line1_step;
        (frame_on && adv_src == sq_pkg::SQ_SRC_LINE1 && !rst_hit && (line_sync[0] ^ inv[0]))
            |=> pend_sync_adv;
    endproperty
    a_line1_step: assert property (p_line1_step) else $error("line status 1 did not step");

    property p_enable_bank0;
        $rose(pend_start) |-> ##[1:4] s_bank0_loaded;
    endproperty
    a_enable_bank0: assert property (p_enable_bank0) else $error("enable did not load bank 0");

    property p_load_data;
        (state == sq_pkg::SQ_FETCH && tgt_valid) |=> (o_active_set == $past(mio.rdata));
    endproperty
    a_load_data: assert property (p_load_data) else $error("active set not loaded from bank");

    property p_store_valid;
        do_store |=> valid[$past(index)];
    endproperty
    a_store_valid: assert property (p_store_valid) else $error("stored bank not marked");

    property p_default_set;
        (state == sq_pkg::SQ_FETCH && !tgt_valid) |=> (o_active_set == `SQ_DEFAULT_SET);
    endproperty
    a_default_set: assert property (p_default_set) else $error("unstored bank not default");

    property p_step_served;
        (go && clr[4]) |=> (state == sq_pkg::SQ_FETCH && seq_q) ##1 o_set_loaded;
    endproperty
    a_step_served: assert property (p_step_served) else $error("step command not applied");
endmodule // sq_controlled_seq

// ==== sq_trig_model.sv ====
// Trigger source model: frame start pulses and two input lines
`timescale 1ns/1ps
module sq_trig_model (
    input  wire logic i_clk_sys,
    output logic      o_frame_start,
    output logic      o_line1,
    output logic      o_line2
);
    initial begin
        o_frame_start = 1'b0;
        o_line1       = 1'b0;
        o_line2       = 1'b0;
    end

    // Lines settle well ahead of a trigger so the synchronisers pass them
    task automatic set_lines(input logic l1, input logic l2);
        @(posedge i_clk_sys);
        o_line1 <= l1;
        o_line2 <= l2;
        repeat (4) @(posedge i_clk_sys);
    endtask

    // One-cycle trigger pulse
    task automatic frame();
        @(posedge i_clk_sys);
        o_frame_start <= 1'b1;
        @(posedge i_clk_sys);
        o_frame_start <= 1'b0;
    endtask
endmodule // sq_trig_model

// ==== tb_top.sv ====
// Self-checking bench for the controlled sequencer
`timescale 1ns/1ps
`include "sq_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic        i_clk_sys = 1'b0;
    logic        i_srst    = 1'b1;
    logic [7:0]  i_addr    = 8'h00;
    logic [31:0] i_wdata   = 32'h0;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic [31:0] o_rdata;
    logic [31:0] o_active_set;
    logic [5:0]  o_bank;
    logic        o_set_loaded;
    logic        frame_s;
    logic        line1_s;
    logic        line2_s;
    int          n_errors  = 0;
    int          checked   = 0;
    int          cycles    = 0;

    always #5 i_clk_sys = ~i_clk_sys;

    sq_controlled_seq i_dut (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_frame_start(frame_s),
        .i_line1(line1_s), .i_line2(line2_s), .o_active_set(o_active_set),
        .o_bank(o_bank), .o_set_loaded(o_set_loaded));

    sq_trig_model i_trig (.i_clk_sys(i_clk_sys), .o_frame_start(frame_s),
        .o_line1(line1_s), .o_line2(line2_s));

    // Banks 0..2 are stored, bank 3 is left at its default
    function automatic logic [31:0] bdat(input int i);
        return (i < 3) ? 32'h5A00_0000 + i : `SQ_DEFAULT_SET;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        @(negedge i_clk_sys);
        `CHK(o_rdata, e)
    endtask

    task automatic wait_load(input logic [5:0] b, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge i_clk_sys);
        while (o_set_loaded !== 1'b1 && n < 20) begin
            @(negedge i_clk_sys);
            n++;
        end
        `CHK(o_set_loaded, 1'b1)
        `CHK(o_bank, b)
        `CHK(o_active_set, d)
    endtask

    task automatic no_load(input logic [5:0] b);
        repeat (10) begin
            @(negedge i_clk_sys);
            `CHK(o_set_loaded, 1'b0)
        end
        `CHK(o_bank, b)
    endtask

    // Sources change only while disabled; enabling starts again at bank 0
    task automatic cfg(input logic [3:0] src, input logic [1:0] inv);
        wr(`SQ_OFF_CTRL, 32'h0);
        wr(`SQ_OFF_SRC, {28'h0, src});
        wr(`SQ_OFF_INV, {30'h0, inv});
        wr(`SQ_OFF_CTRL, 32'h1);
        wait_load(6'h00, bdat(0));
    endtask

    task automatic t_regs();
        rd_chk(`SQ_OFF_CTRL, 32'h0);
        rd_chk(`SQ_OFF_TOTAL, 32'h1);
        rd_chk(`SQ_OFF_SRC, 32'h0);
        rd_chk(8'h40, 32'h0);
        wr(`SQ_OFF_TOTAL, 32'h0);
        rd_chk(`SQ_OFF_TOTAL, 32'h1);
        wr(`SQ_OFF_TOTAL, 32'hC8);
        rd_chk(`SQ_OFF_TOTAL, 32'h40);
        wr(`SQ_OFF_TOTAL, 32'h4);
    endtask

    task automatic t_store();
        wr(`SQ_OFF_ACTIVE, 32'hFFFF_FFFF);
        wr(`SQ_OFF_INDEX, 32'h2);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STORE);
        for (int i = 0; i < 3; i++) begin
            wr(`SQ_OFF_ACTIVE, bdat(i));
            rd_chk(`SQ_OFF_ACTIVE, bdat(i));
            wr(`SQ_OFF_INDEX, i);
            wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STORE);
        end
        wr(`SQ_OFF_ACTIVE, 32'h0000_C0DE);
        wr(`SQ_OFF_INDEX, 32'h3F);
        rd_chk(`SQ_OFF_INDEX, 32'h3F);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STORE);
        wr(`SQ_OFF_INDEX, 32'h3);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_LOAD);
        wait_load(6'h00, `SQ_DEFAULT_SET);
        wr(`SQ_OFF_INDEX, 32'h3F);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_LOAD);
        wait_load(6'h00, 32'h0000_C0DE);
        wr(`SQ_OFF_INDEX, 32'h2);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_LOAD);
        wait_load(6'h00, bdat(2));
    endtask

    task automatic t_always();
        cfg(4'h1, 2'b00);
        for (int k = 1; k < 6; k++) begin
            i_trig.frame();
            wait_load(6'(k % 4), bdat(k % 4));
        end
    endtask

    task automatic t_lines();
        cfg(4'h2, 2'b00);
        i_trig.set_lines(1'b1, 1'b0);
        no_load(6'h00);
        i_trig.set_lines(1'b0, 1'b1);
        i_trig.frame();
        no_load(6'h00);
        i_trig.set_lines(1'b1, 1'b0);
        i_trig.frame();
        wait_load(6'h01, bdat(1));
        cfg(4'h2, 2'b01);
        i_trig.frame();
        no_load(6'h00);
        i_trig.set_lines(1'b0, 1'b0);
        i_trig.frame();
        wait_load(6'h01, bdat(1));
        cfg(4'h3, 2'b00);
        i_trig.set_lines(1'b0, 1'b1);
        i_trig.frame();
        wait_load(6'h01, bdat(1));
        cfg(4'h3, 2'b10);
        rd_chk(`SQ_OFF_SRC, 32'h3);
        rd_chk(`SQ_OFF_INV, 32'h2);
        i_trig.frame();
        no_load(6'h00);
        i_trig.set_lines(1'b0, 1'b0);
        i_trig.frame();
        wait_load(6'h01, bdat(1));
    endtask

    task automatic t_restart();
        cfg(4'hD, 2'b00);
        i_trig.set_lines(1'b0, 1'b0);
        i_trig.frame();
        wait_load(6'h01, bdat(1));
        i_trig.frame();
        wait_load(6'h02, bdat(2));
        i_trig.set_lines(1'b0, 1'b1);
        i_trig.frame();
        wait_load(6'h00, bdat(0));
        cfg(4'h9, 2'b01);
        i_trig.set_lines(1'b1, 1'b0);
        i_trig.frame();
        wait_load(6'h01, bdat(1));
        i_trig.set_lines(1'b0, 1'b0);
        i_trig.frame();
        wait_load(6'h00, bdat(0));
    endtask

    task automatic t_cmds();
        cfg(4'h0, 2'b00);
        i_trig.frame();
        no_load(6'h00);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STEP);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STEP);
        repeat (20) @(negedge i_clk_sys);
        `CHK(o_bank, 6'h02)
        `CHK(o_active_set, bdat(2))
        rd_chk(`SQ_OFF_STATUS, 32'h0000_8002);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STEP);
        wait_load(6'h03, `SQ_DEFAULT_SET);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STEP);
        wait_load(6'h00, bdat(0));
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STEP);
        wait_load(6'h01, bdat(1));
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_REWIND);
        wait_load(6'h00, bdat(0));
        i_trig.set_lines(1'b1, 1'b1);
        i_trig.frame();
        no_load(6'h00);
        // Restart source set to always acts as disabled
        cfg(4'h4, 2'b00);
        wr(`SQ_OFF_CMD, 32'h1 << `SQ_CMD_STEP);
        wait_load(6'h01, bdat(1));
        i_trig.frame();
        no_load(6'h01);
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang ends the run as a failure
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        @(negedge i_clk_sys);
        `CHK(o_bank, 6'h00)
        `CHK(o_active_set, 32'h0)
        t_regs();
        t_store();
        t_always();
        t_lines();
        t_restart();
        t_cmds();
        report_and_stop();
    end
endmodule // tb_top
